// ---- hdl/ahi_regs.svh ----
/*
 * Register map, bit positions and reset values of the adaptive host port.
 * Assumes it is included by bare name from the package and the design.
 */
`ifndef AHI_REGS_SVH
`define AHI_REGS_SVH

// Register select line values.
`define AHI_SEL_DATA 1'b0
`define AHI_SEL_CTRL 1'b1

// Control bank A bit positions.
`define AHI_A_TONE 0
`define AHI_A_CALLP 1
`define AHI_A_IRQ 2
`define AHI_A_PTR 3

// Control bank B bit positions.
`define AHI_B_BURST 0
`define AHI_B_RXOFF 1
`define AHI_B_SINGLE 2
`define AHI_B_COLUMN 3

// Status bit positions.
`define AHI_ST_IRQ 0
`define AHI_ST_TXE 1
`define AHI_ST_RXF 2
`define AHI_ST_STEER 3

// Reset values of the four-bit registers.
`define AHI_NIB_RST 4'h0

`endif

// ---- hdl/ahi_pkg.sv ----
/*
 * Types shared by the adaptive host port.
 * Assumes ahi_regs.svh is on the include path.
 */
package ahi_pkg;
    `include "ahi_regs.svh"

    // Bus style sensed at the chip-select falling edge, one-hot.
    typedef enum logic [2:0] {
        AHI_IDLE = 3'b001,
        AHI_ONE_STROBE = 3'b010,
        AHI_TWO_STROBE = 3'b100
    } ahi_style_t;

    // One register nibble.
    typedef logic [3:0] ahi_nib_t;
endpackage

// ---- hdl/ahi_host_port.sv ----
/*
 * Adaptive parallel host port and control bank of a tone transceiver.
 * Assumes host pins are synchronous to ref_clk and a tone core outside
 * supplies detection events and consumes the control outputs.
 */
`timescale 1ns/1ps
`include "ahi_regs.svh"

// Operation
// - Data strobe low at select fall: single-strobe.
// - Read strobe high at select fall: split strobes.
// - Latch address per detected multiplexed bus type.
// - Status updates need no strobe activity.
// - Select 0: data registers; 1: control/status.
// - Receive register holds last valid tone code.
// - Transmit write picks tone pair, same code.
// - Bank A bit3 steers next write to B.
// - Interrupt pin is open-drain, pulled up outside.
// - Bank A bit0 gates all tone output.
// - Bank A bit1 selects call-progress, no detection.
// - Call-progress square wave only when interrupts enabled.
// - Interrupt low on tone valid or burst ready.
// - Bank B bit0 low enables burst mode.
// - Bank B bits select single tone, column/row.
// - Status flag bits clear on status read; the steering bit follows rx_steer.
module ahi_host_port
    import ahi_pkg::*;
(
    // Clock, reset and freeze.
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // Host bus pins.
    input wire logic cs_n,
    input wire logic data_strobe_in,
    input wire logic rw_wr,
    input wire logic register_select_line,
    input wire logic [3:0] data_in,
    output logic [3:0] data_out,
    output logic data_oe,
    // Open-drain interrupt / call-progress pin.
    output logic interrupt_tone_pin_out,
    output logic interrupt_tone_pin_oe,
    // Events and levels from the tone core.
    input wire logic rx_valid,
    input wire logic [3:0] rx_code,
    input wire logic rx_steer,
    input wire logic tx_done,
    input wire logic cp_square_in,
    // Controls toward the tone core.
    output logic [3:0] tx_code,
    output logic tx_load,
    output logic tone_output_enable,
    output logic call_progress_select,
    output logic burst_disable,
    output logic receiver_off,
    output logic single_tone,
    output logic column_tone
);

    ////////////////////////////////////////////////////////////////////////
    // Pin sampling and strobe decode.

    logic cs_q_r; // Chip select one cycle ago.
    logic strobe_q_r; // Data/read strobe one cycle ago.
    logic wr_q_r; // Write strobe active one cycle ago.
    logic rd_q_r; // Read strobe active one cycle ago.
    ahi_style_t style_r; // Bus style of the current access.
    logic addr_r; // Latched register select.
    ahi_nib_t wdat_r; // Write data held while the strobe is active.
    logic cs_fall; // Chip select falling edge.
    logic strobe_rise; // Single-strobe data strobe rising edge.
    logic wr_act; // Write strobe active in the current style.
    logic rd_act; // Read strobe active in the current style.
    logic wr_end; // Trailing edge of a write strobe.
    logic rd_end; // Trailing edge of a read strobe.

    // The style is only trusted after it has been sensed, so a select
    // held low out of reset still counts as a fall, as cs_q_r resets high.
    assign cs_fall = cs_q_r & ~cs_n;
    assign strobe_rise = (style_r == AHI_ONE_STROBE) & ~cs_n
        & data_strobe_in & ~strobe_q_r;

    // Decode both bus styles into one internal write and read strobe.
    // In the select-fall cycle the style still belongs to the previous
    // access, so nothing is decoded there; a stale style could otherwise
    // fake a read strobe edge and clear status during a write.
    always_comb begin
        wr_act = 1'b0;
        rd_act = 1'b0;
        if (cs_n || cs_fall) begin
            // No access without select, nor before the style is sensed.
            wr_act = 1'b0;
        end else if (style_r == AHI_ONE_STROBE) begin
            // Data strobe high is the active phase; direction line tells.
            wr_act = data_strobe_in & ~rw_wr;
            rd_act = data_strobe_in & rw_wr;
        end else if (style_r == AHI_TWO_STROBE) begin
            // Separate low-active strobes.
            wr_act = ~rw_wr;
            rd_act = ~data_strobe_in;
        end
    end

    assign wr_end = wr_q_r & ~wr_act;
    assign rd_end = rd_q_r & ~rd_act;

    // Previous pin and strobe levels for edge detection.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_q_r <= 1'b1;
            strobe_q_r <= 1'b0;
            wr_q_r <= 1'b0;
            rd_q_r <= 1'b0;
        end else if (clk_en) begin
            cs_q_r <= cs_n;
            strobe_q_r <= data_strobe_in;
            wr_q_r <= wr_act;
            rd_q_r <= rd_act;
        end
    end

    // Sense the bus style on each select fall.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            style_r <= AHI_IDLE;
        end else if (clk_en && cs_fall) begin
            if (!data_strobe_in) begin
                style_r <= AHI_ONE_STROBE;
            end else begin
                style_r <= AHI_TWO_STROBE;
            end
        end
    end

    // Multiplexed buses present the address with select; separate buses
    // hold it valid when the data strobe rises.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= `AHI_SEL_DATA;
        end else if (clk_en && (cs_fall || strobe_rise)) begin
            addr_r <= register_select_line;
        end
    end

    // Track data while the write strobe is active; the last value seen
    // before the trailing edge is what gets committed.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wdat_r <= `AHI_NIB_RST;
        end else if (clk_en && wr_act) begin
            wdat_r <= data_in;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Data and control registers.

    ahi_nib_t tx_code_r; // Transmit tone code.
    ahi_nib_t rx_code_r; // Last valid received code.
    ahi_nib_t bank_a_r; // Control bank A.
    ahi_nib_t bank_b_r; // Control bank B.
    logic bank_pointer_bit_r; // Next control write goes to bank B.
    logic tx_load_r; // One-cycle pulse after a transmit write.
    logic wr_data; // Commit to the transmit register.
    logic wr_ctrl; // Commit to a control bank.

    assign wr_data = wr_end & (addr_r == `AHI_SEL_DATA);
    assign wr_ctrl = wr_end & (addr_r == `AHI_SEL_CTRL);

    // Transmit register and its load pulse toward the synthesiser.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_code_r <= `AHI_NIB_RST;
            tx_load_r <= 1'b0;
        end else if (clk_en) begin
            tx_load_r <= wr_data;
            if (wr_data) begin
                tx_code_r <= wdat_r;
            end
        end
    end

    // Receive register loads only in tone-pair mode; in call-progress
    // mode detection is off and the old code is kept.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_code_r <= `AHI_NIB_RST;
        end else if (clk_en && rx_valid && !bank_a_r[`AHI_A_CALLP]) begin
            rx_code_r <= rx_code;
        end
    end

    // Both banks share one address; bank A bit3 steers the next write to B.
    // Reset clears them, though software still initialises them.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            bank_a_r <= `AHI_NIB_RST;
            bank_b_r <= `AHI_NIB_RST;
            bank_pointer_bit_r <= 1'b0;
        end else if (clk_en && wr_ctrl) begin
            if (!bank_pointer_bit_r) begin
                bank_a_r <= wdat_r;
                bank_pointer_bit_r <= wdat_r[`AHI_A_PTR];
            end else begin
                bank_b_r <= wdat_r;
                bank_pointer_bit_r <= 1'b0;
            end
        end
    end

    // Control outputs come straight from the bank flops.
    assign tone_output_enable = bank_a_r[`AHI_A_TONE];
    assign call_progress_select = bank_a_r[`AHI_A_CALLP];
    assign burst_disable = bank_b_r[`AHI_B_BURST];
    assign receiver_off = bank_b_r[`AHI_B_RXOFF];
    assign single_tone = bank_b_r[`AHI_B_SINGLE];
    assign column_tone = bank_b_r[`AHI_B_COLUMN];
    assign tx_code = tx_code_r;
    assign tx_load = tx_load_r;

    ////////////////////////////////////////////////////////////////////////
    // Status, read path and interrupt pin.

    logic st_txe_r; // Transmitter ready, burst mode only.
    logic st_rxf_r; // Receive register full.
    logic st_steer_r; // Delayed steering level.
    logic rd_status; // Status read completes.
    logic st_irq; // Interrupt occurred.
    ahi_nib_t status; // Status word.
    ahi_nib_t rdat_r; // Registered read data.
    logic int_oe_r; // Pin pulled low.

    assign rd_status = rd_end & (addr_r == `AHI_SEL_CTRL);
    assign st_irq = st_txe_r | st_rxf_r;
    assign status = {st_steer_r, st_rxf_r, st_txe_r, st_irq};

    // Flags follow core events on their own; a set in the same cycle as
    // the clearing read wins so no event is lost.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_txe_r <= 1'b0;
            st_rxf_r <= 1'b0;
            st_steer_r <= 1'b0;
        end else if (clk_en) begin
            st_steer_r <= rx_steer;
            if (rx_valid && !bank_a_r[`AHI_A_CALLP]) begin
                st_rxf_r <= 1'b1;
            end else if (rd_status) begin
                st_rxf_r <= 1'b0;
            end
            if (bank_b_r[`AHI_B_BURST]) begin
                st_txe_r <= 1'b0;
            end else if (tx_done) begin
                st_txe_r <= 1'b1;
            end else if (rd_status) begin
                st_txe_r <= 1'b0;
            end
        end
    end

    // Read data is registered and lags the address by one cycle.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdat_r <= `AHI_NIB_RST;
        end else if (clk_en) begin
            if (addr_r == `AHI_SEL_CTRL) begin
                rdat_r <= status;
            end else begin
                rdat_r <= rx_code_r;
            end
        end
    end

    assign data_out = rdat_r;
    assign data_oe = rd_act;

    // Pin pulls low for a pending flag in tone-pair mode, or follows the
    // comparator level in call-progress mode; both need the enable.
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            int_oe_r <= 1'b0;
        end else if (clk_en) begin
            if (!bank_a_r[`AHI_A_IRQ]) begin
                int_oe_r <= 1'b0;
            end else if (bank_a_r[`AHI_A_CALLP]) begin
                int_oe_r <= ~cp_square_in;
            end else begin
                int_oe_r <= st_irq;
            end
        end
    end

    // Open drain: never drive high.
    assign interrupt_tone_pin_out = 1'b0;
    assign interrupt_tone_pin_oe = int_oe_r;

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    a_single_sense: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && cs_fall && !data_strobe_in |=> style_r == AHI_ONE_STROBE)
        else $error("single-strobe style not sensed");

    a_split_sense: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && cs_fall && data_strobe_in |=> style_r == AHI_TWO_STROBE)
        else $error("split-strobe style not sensed");

    a_addr_latch: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && cs_fall |=> addr_r == $past(register_select_line))
        else $error("address not latched at select fall");

    a_rx_full_set: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && rx_valid && !bank_a_r[`AHI_A_CALLP] |=> st_rxf_r)
        else $error("receive full not set");

    a_tx_write: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr_data |=> tx_code_r == $past(wdat_r) && tx_load)
        else $error("transmit write not committed");

    a_rx_hold: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && rx_valid && !bank_a_r[`AHI_A_CALLP]
        |=> rx_code_r == $past(rx_code))
        else $error("receive code not captured");

    a_bank_steer: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr_ctrl && !bank_pointer_bit_r && wdat_r[`AHI_A_PTR]
        |=> bank_pointer_bit_r ##0 bank_a_r == $past(wdat_r))
        else $error("bank pointer not set");

    a_bank_return: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && wr_ctrl && bank_pointer_bit_r
        |=> !bank_pointer_bit_r ##0 bank_b_r == $past(wdat_r))
        else $error("bank B write wrong");

    a_cp_wave: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && bank_a_r[`AHI_A_IRQ] && bank_a_r[`AHI_A_CALLP]
        |=> int_oe_r == !$past(cp_square_in))
        else $error("call-progress wave missing");

    a_irq_pull: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && bank_a_r[`AHI_A_IRQ] && !bank_a_r[`AHI_A_CALLP] && st_irq
        |=> int_oe_r)
        else $error("interrupt not asserted");

    a_status_clear: assert property (
        @(posedge ref_clk) disable iff (!rst_n)
        clk_en && rd_status && !rx_valid && !tx_done |=> !st_irq)
        else $error("status not cleared by read");

endmodule

// ---- verif/ahi_host_model.sv ----
/*
 * Host processor model that drives the adaptive host port bus.
 * Assumes the bench calls access() and leaves the pins alone otherwise.
 */
`timescale 1ns/1ps

module ahi_host_model (
    // Clock.
    input wire logic ref_clk,
    // Bus toward the port.
    output logic cs_n = 1'b1,
    output logic data_strobe_in = 1'b1,
    output logic rw_wr = 1'b1,
    output logic register_select_line = 1'b0,
    output logic [3:0] data_in = 4'h0,
    // Read answer from the port.
    input wire logic [3:0] data_out,
    input wire logic data_oe
);
    ////////////////////////////////////////////////////////////////////////
    // One access, split strobes (s=1) or single strobe (s=0).
    // Pins move only at falling edges so the port samples settled levels.
    task automatic access(input logic s, input logic rd, input logic rs,
                          input logic [3:0] wd, output logic [3:0] q);
        @(negedge ref_clk);
        cs_n = 1'b0;
        // Strobe level at the select fall tells the port the bus style.
        data_strobe_in = s;
        rw_wr = s | rd;
        register_select_line = rs;
        data_in = wd;
        @(negedge ref_clk);
        if (!s) begin
            data_strobe_in = 1'b1;
        end else if (rd) begin
            data_strobe_in = 1'b0;
        end else begin
            rw_wr = 1'b0;
        end
        repeat (2) @(negedge ref_clk);
        // Only data the port really drives counts as an answer; it is
        // taken at a falling edge, where the registered read data settled.
        q = data_oe ? data_out : 4'hx;
        @(negedge ref_clk);
        data_strobe_in = s;
        rw_wr = s | rd;
        @(negedge ref_clk);
        cs_n = 1'b1;
        // Released lines do not keep their last value.
        data_in = ~wd;
        register_select_line = ~rs;
        repeat (2) @(negedge ref_clk);
    endtask
endmodule

// ---- verif/test_adaptive_host_interface.sv ----
/*
 * Self-checking bench of the adaptive host port.
 * Assumes the host model is compiled before this file.
 */
`timescale 1ns/1ps

module test_adaptive_host_interface;
    // Clock, reset and core-side stimulus.
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic rx_valid = 1'b0;
    logic tx_done = 1'b0;
    logic cp_square_in = 1'b0;
    logic clk_en = 1'b1;
    logic rx_steer = 1'b0;
    logic [3:0] rx_code = 4'h0;
    // Bus pins between model and port.
    wire logic cs_n, data_strobe_in, rw_wr, register_select_line, data_oe;
    wire logic [3:0] data_in, data_out, tx_code;
    // Port outputs toward the core and the pin.
    wire logic interrupt_tone_pin_out, interrupt_tone_pin_oe, tx_load;
    wire logic tone_output_enable, call_progress_select, burst_disable;
    wire logic receiver_off, single_tone, column_tone;
    // Pin level with the outside pull-up.
    wire logic irq_pin = interrupt_tone_pin_oe ? interrupt_tone_pin_out : 1'b1;
    wire logic [3:0] ctl_a = {2'b00, call_progress_select, tone_output_enable};
    wire logic [3:0] ctl_b = {column_tone, single_tone, receiver_off,
                              burst_disable};
    int err_count = 0;
    int num_checks = 0;
    int tx_loads = 0;
    logic [3:0] q;

    always #12.5 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////
    // Design and host model; freeze and steering are driven by the bench.
    ahi_host_port dut_u (.ref_clk, .rst_n, .clk_en, .cs_n,
        .data_strobe_in, .rw_wr, .register_select_line, .data_in, .data_out,
        .data_oe, .interrupt_tone_pin_out, .interrupt_tone_pin_oe, .rx_valid,
        .rx_code, .rx_steer, .tx_done, .cp_square_in, .tx_code,
        .tx_load, .tone_output_enable, .call_progress_select, .burst_disable,
        .receiver_off, .single_tone, .column_tone);
    ahi_host_model host_u (.ref_clk, .cs_n, .data_strobe_in, .rw_wr,
        .register_select_line, .data_in, .data_out, .data_oe);

    // Counts transmit load pulses; each transmit write must give exactly one.
    always @(posedge ref_clk) begin
        if (tx_load === 1'b1) begin
            tx_loads++;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared helpers.
    task automatic check(input string name, input logic [3:0] seen,
                         input logic [3:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic s, input logic rs, input logic [3:0] d);
        host_u.access(s, 1'b0, rs, d, q);
    endtask

    task automatic rd(input logic s, input logic rs);
        host_u.access(s, 1'b1, rs, 4'h0, q);
    endtask

    // One-cycle event from the tone core, then time for the pin to follow.
    task automatic pulse(input logic t, input logic [3:0] c);
        @(negedge ref_clk);
        rx_code = c;
        rx_valid = !t;
        tx_done = t;
        @(negedge ref_clk);
        rx_valid = 1'b0;
        tx_done = 1'b0;
        repeat (2) @(negedge ref_clk);
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Scenarios.
    task automatic t_init;
        check("pin_drive", {3'b000, interrupt_tone_pin_out}, 4'h0);
        check("pin_idle", {3'b000, irq_pin}, 4'h1);
        rd(1'b1, 1'b1);
        wr(1'b1, 1'b1, 4'h0);
        wr(1'b1, 1'b1, 4'h0);
        wr(1'b1, 1'b1, 4'h8);
        wr(1'b1, 1'b1, 4'h0);
        check("init_b", ctl_b, 4'h0);
        check("init_a", ctl_a, 4'h0);
    endtask

    // Pointer bit steers one write to bank B, single strobe style for it.
    task automatic t_banks;
        wr(1'b1, 1'b1, 4'hd);
        check("a_first", ctl_a, 4'h1);
        wr(1'b0, 1'b1, 4'he);
        check("b_write", ctl_b, 4'he);
        wr(1'b1, 1'b1, 4'h2);
        check("a_back", ctl_a, 4'h2);
        wr(1'b1, 1'b1, 4'h0);
        check("b_kept", ctl_b, 4'he);
        check("a_again", ctl_a, 4'h0);
    endtask

    task automatic t_tx;
        wr(1'b0, 1'b0, 4'h7);
        check("tx_single", tx_code, 4'h7);
        wr(1'b1, 1'b0, 4'hc);
        check("tx_split", tx_code, 4'hc);
        check("tx_loads", tx_loads[3:0], 4'h2);
    endtask

    // Detection with no bus activity, then read back and clear.
    task automatic t_rx;
        wr(1'b1, 1'b1, 4'h4);
        pulse(1'b0, 4'h9);
        check("rx_irq", {3'b000, irq_pin}, 4'h0);
        rd(1'b0, 1'b0);
        check("rx_code", q, 4'h9);
        rx_steer = 1'b1;
        rd(1'b0, 1'b1);
        check("rx_stat", q, 4'hd);
        rd(1'b1, 1'b1);
        check("rx_clear", q, 4'h8);
        rx_steer = 1'b0;
        check("rx_release", {3'b000, irq_pin}, 4'h1);
        // A tone seen while frozen must leave code and flags untouched.
        clk_en = 1'b0;
        pulse(1'b0, 4'h5);
        clk_en = 1'b1;
        rd(1'b1, 1'b0);
        check("frz_code", q, 4'h9);
    endtask

    // Bank B bit0 is low here, so burst mode is active.
    task automatic t_burst;
        pulse(1'b1, 4'h0);
        check("bu_irq", {3'b000, irq_pin}, 4'h0);
        rd(1'b1, 1'b1);
        check("bu_stat", q, 4'h3);
        rd(1'b0, 1'b1);
        check("bu_clear", q, 4'h0);
        wr(1'b1, 1'b1, 4'hc);
        wr(1'b1, 1'b1, 4'h1);
        pulse(1'b1, 4'h0);
        rd(1'b1, 1'b1);
        check("nb_stat", q, 4'h0);
    endtask

    task automatic t_cp;
        wr(1'b1, 1'b1, 4'h6);
        repeat (2) @(negedge ref_clk);
        check("cp_low", {3'b000, irq_pin}, 4'h0);
        cp_square_in = 1'b1;
        repeat (2) @(negedge ref_clk);
        check("cp_high", {3'b000, irq_pin}, 4'h1);
        pulse(1'b0, 4'h3);
        rd(1'b1, 1'b1);
        check("cp_stat", q, 4'h0);
        rd(1'b1, 1'b0);
        check("cp_code", q, 4'h9);
        wr(1'b1, 1'b1, 4'h2);
        cp_square_in = 1'b0;
        repeat (2) @(negedge ref_clk);
        check("cp_noirq", {3'b000, irq_pin}, 4'h1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence and hang guard.
    initial begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge ref_clk);
        t_init();
        t_banks();
        t_tx();
        t_rx();
        t_burst();
        t_cp();
        give_verdict();
    end

    // The whole run needs far fewer cycles; running out means a hang.
    initial begin
        repeat (6000) @(posedge ref_clk);
        err_count++;
        $display("[FAIL] run_length expected end seen limit");
        give_verdict();
    end
endmodule
